// ==== src/tw_pkg.sv ====
// constants and types for the two-wire master transmit block
// Operation
// RL1: flag set once START is on the bus
// RL2: flag set after address byte sent and acknowledge sampled
// RL3: flag set after data byte sent and acknowledge sampled
// RL4: status low bits hold prescaler; code sits in upper five bits
// RL5: clearing flag with enable, no start or stop, sends data byte
// RL6: software loads target address and write bit before address phase
// RL7: software loads next payload byte before clearing flag
// RL8: software checks masked status each step, branches on mismatch
// RL9: direction bit is high for read, low for write
// RL10: acknowledge is data line low, not-acknowledge high; bytes eight bits
// RL11: transfer suspended, clock held low, while flag set
// RL12: four roles exist; role reported, master send performed here
// RL13: software picks next action from status code alone
// RL14: start or repeated start: enable, start and flag bits, no stop
// RL15: stop: enable, stop and flag bits, no start
// RL16: after START status reads start-sent code
// RL17: after address status reads acked or not-acked code
// RL18: no new bus operation while flag set; clearing starts it
// RL19: flag not set after STOP
package tw_pkg;
    localparam logic [7:0] TW_CTRL_OFS = 8'h00;
    localparam logic [7:0] TW_STAT_OFS = 8'h04;
    localparam logic [7:0] TW_DATA_OFS = 8'h08;
    localparam logic [7:0] TW_RATE_OFS = 8'h0C;
    localparam logic [7:0] TW_ROLE_OFS = 8'h10;
    localparam logic [7:0] TW_IRQS_OFS = 8'h14;
    localparam logic [7:0] TW_IRQC_OFS = 8'h18;
    localparam logic [7:0] TW_IRQE_OFS = 8'h1C;
    // control bit positions
    localparam int TW_B_FLAG = 7;
    localparam int TW_B_STA = 5;
    localparam int TW_B_STO = 4;
    localparam int TW_B_WC = 3;
    localparam int TW_B_EN = 2;
    localparam logic [7:0] TW_CODE_MASK = 8'hF8;
    localparam logic [4:0] TW_C_START = 5'h01; // 0x08
    localparam logic [4:0] TW_C_RSTART = 5'h02; // 0x10
    localparam logic [4:0] TW_C_AACK = 5'h03; // 0x18
    localparam logic [4:0] TW_C_ANACK = 5'h04; // 0x20
    localparam logic [4:0] TW_C_DACK = 5'h05; // 0x28
    localparam logic [4:0] TW_C_DNACK = 5'h06; // 0x30
    localparam logic [4:0] TW_C_NONE = 5'h1F; // 0xF8
    localparam logic [7:0] TW_RATE_RST = 8'h0A;
    localparam logic [1:0] TW_PRESC_RST = 2'h0;
    localparam logic [2:0] TW_LAST_BIT = 3'h7;
    localparam int TW_NIRQ = 3;
    typedef enum logic [2:0] {
        TW_FS_IDLE = 3'b000,
        TW_FS_START = 3'b001,
        TW_FS_BIT = 3'b010,
        TW_FS_ACK = 3'b011,
        TW_FS_HOLD = 3'b100,
        TW_FS_STOP = 3'b101
    } tw_state_t;
    typedef enum logic [1:0] {
        TW_R_MSEND = 2'b00,
        TW_R_MRECV = 2'b01,
        TW_R_SSEND = 2'b10,
        TW_R_SRECV = 2'b11
    } tw_role_t;
endpackage

// ==== src/tw_sync3.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tw_sync3 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_r, s2_r, s3_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // only a settled value counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_o <= 1'b1;
        end else if (s2_r == s3_r) begin
            level_o <= s3_r;
        end
    end
endmodule
`default_nettype wire

// ==== src/tw_tick.sv ====
// quarter-bit enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module tw_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] rate,
    input wire logic [1:0] presc,
    output logic tick
);
    logic [15:0] cnt_r;
    logic [15:0] lim;
    assign lim = 16'({8'h00, rate} << {presc, 1'b0});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (!run || cnt_r >= lim) begin
            cnt_r <= 16'h0000;
            tick <= run;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== src/tw_core.sv ====
// two-wire master transmitter with apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module tw_core
    import tw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    tw_state_t state_r;
    logic [1:0] ph_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r, data_r, rate_r;
    logic [1:0] presc_r;
    logic [4:0] code_r;
    logic flag_r, sta_r, sto_r, wc_r, en_r;
    logic is_addr_r, held_r, nack_r;
    tw_role_t role_r;
    logic [TW_NIRQ-1:0] ists_r, iena_r;
    logic scl_s, sda_s, tick, set_flag, stop_done;
    logic [31:0] rd;

    tw_sync3 u_scl (
        .pclk(pclk),
        .presetn(presetn),
        .pin_i(scl_i),
        .level_o(scl_s)
    );
    tw_sync3 u_sda (
        .pclk(pclk),
        .presetn(presetn),
        .pin_i(sda_i),
        .level_o(sda_s)
    );
    tw_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(en_r && state_r != TW_FS_IDLE && state_r != TW_FS_HOLD),
        .rate(rate_r),
        .presc(presc_r),
        .tick(tick)
    );

    // apb decode
    logic wr, acc;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction
    logic mapped;
    assign mapped = hit(paddr, TW_CTRL_OFS) || hit(paddr, TW_STAT_OFS) ||
        hit(paddr, TW_DATA_OFS) || hit(paddr, TW_RATE_OFS) ||
        hit(paddr, TW_ROLE_OFS) || hit(paddr, TW_IRQS_OFS) ||
        hit(paddr, TW_IRQC_OFS) || hit(paddr, TW_IRQE_OFS);
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    logic ctrl_wr, go;
    assign ctrl_wr = wr && hit(paddr, TW_CTRL_OFS);
    // writing one to the flag bit with enable set releases the engine
    assign go = ctrl_wr && pwdata[TW_B_FLAG] && pwdata[TW_B_EN]; // RL5 RL14 RL15
    logic busy;
    assign busy = state_r != TW_FS_IDLE && state_r != TW_FS_HOLD;

    always_comb begin
        rd = 32'h0000_0000;
        unique case (1'b1)
            hit(paddr, TW_CTRL_OFS):
                rd[7:0] = {flag_r, 1'b0, sta_r, sto_r, wc_r, en_r, 2'b00};
            // code masked to f8 unless flag set
            hit(paddr, TW_STAT_OFS):
                rd[7:0] = {flag_r ? code_r : TW_C_NONE, 1'b0, presc_r}; // RL4
            hit(paddr, TW_DATA_OFS): rd[7:0] = data_r;
            hit(paddr, TW_RATE_OFS): rd[7:0] = rate_r;
            hit(paddr, TW_ROLE_OFS): rd[1:0] = role_r; // RL12
            hit(paddr, TW_IRQS_OFS): rd[TW_NIRQ-1:0] = ists_r;
            hit(paddr, TW_IRQE_OFS): rd[TW_NIRQ-1:0] = iena_r;
            default: rd = 32'h0000_0000;
        endcase
    end
    // read data latched in setup phase, so access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_r <= TW_RATE_RST;
            presc_r <= TW_PRESC_RST;
            iena_r <= '0;
        end else begin
            if (wr && hit(paddr, TW_RATE_OFS)) begin
                rate_r <= pwdata[7:0];
            end
            if (wr && hit(paddr, TW_STAT_OFS)) begin
                presc_r <= pwdata[1:0];
            end
            if (wr && hit(paddr, TW_IRQE_OFS)) begin
                iena_r <= pwdata[TW_NIRQ-1:0];
            end
        end
    end

    // data register: writes while a byte is moving collide and are dropped
    logic data_wr, coll;
    assign data_wr = wr && hit(paddr, TW_DATA_OFS);
    assign coll = data_wr && !flag_r && busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= 8'h00;
        end else if (data_wr && !coll) begin
            data_r <= pwdata[7:0];
        end
    end

    // control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            sta_r <= 1'b0;
            sto_r <= 1'b0;
            wc_r <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                en_r <= pwdata[TW_B_EN];
                sta_r <= pwdata[TW_B_STA];
                sto_r <= pwdata[TW_B_STO];
            end else begin
                if (set_flag) begin
                    sta_r <= 1'b0;
                end
                if (stop_done) begin
                    sto_r <= 1'b0;
                end
            end
            if (coll) begin
                wc_r <= 1'b1;
            end else if (ctrl_wr && !pwdata[TW_B_WC]) begin
                wc_r <= 1'b0;
            end
        end
    end

    // completion flag: a hardware set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else if (set_flag) begin
            flag_r <= 1'b1;
        end else if (go || (ctrl_wr && !pwdata[TW_B_EN])) begin
            flag_r <= 1'b0;
        end
    end

    // bus engine, advanced on quarter-bit ticks
    assign set_flag = tick && ph_r == 2'd3 && (state_r == TW_FS_ACK ||
        state_r == TW_FS_START); // RL1 RL2 RL3
    assign stop_done = tick && state_r == TW_FS_STOP && ph_r == 2'd3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= TW_FS_IDLE;
            ph_r <= 2'd0;
            bit_r <= 3'd0;
            shift_r <= 8'h00;
            code_r <= TW_C_NONE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            is_addr_r <= 1'b0;
            held_r <= 1'b0;
            nack_r <= 1'b0;
            role_r <= TW_R_MSEND;
        end else if (!en_r && !go) begin
            // a go write that also sets enable must not be lost
            state_r <= TW_FS_IDLE;
            ph_r <= 2'd0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            held_r <= 1'b0;
        end else begin
            unique case (state_r)
                TW_FS_IDLE, TW_FS_HOLD: begin
                    // nothing moves until the flag is written clear
                    ph_r <= 2'd0; // RL18
                    if (go && !flag_r && state_r == TW_FS_IDLE) begin
                        if (pwdata[TW_B_STA] && !pwdata[TW_B_STO]) begin
                            state_r <= TW_FS_START; // RL14
                        end
                    end else if (go && state_r == TW_FS_HOLD) begin
                        if (pwdata[TW_B_STA] && !pwdata[TW_B_STO]) begin
                            state_r <= TW_FS_START; // RL14
                        end else if (pwdata[TW_B_STO]) begin
                            state_r <= TW_FS_STOP; // RL15
                        end else begin
                            state_r <= TW_FS_BIT; // RL5
                            shift_r <= data_r;
                            bit_r <= 3'd0;
                        end
                    end
                end
                TW_FS_START: if (tick) begin
                    unique case (ph_r)
                        2'd0: begin
                            scl_oe <= 1'b0;
                            sda_oe <= 1'b0;
                            if (scl_s && sda_s) begin
                                ph_r <= 2'd1;
                            end
                        end
                        2'd1: begin
                            sda_oe <= 1'b1;
                            ph_r <= 2'd2;
                        end
                        2'd2: begin
                            // wait for the line to stay high to catch stretch
                            if (scl_s) begin
                                ph_r <= 2'd3;
                            end
                        end
                        2'd3: begin
                            scl_oe <= 1'b1;
                            code_r <= held_r ? TW_C_RSTART : TW_C_START; // RL16
                            held_r <= 1'b1;
                            is_addr_r <= 1'b1;
                            state_r <= TW_FS_HOLD;
                        end
                    endcase
                end
                TW_FS_BIT: if (tick) begin
                    unique case (ph_r)
                        2'd0: begin
                            // low drives zero, release sends one
                            sda_oe <= !shift_r[7]; // RL9
                            ph_r <= 2'd1;
                        end
                        2'd1: begin
                            scl_oe <= 1'b0;
                            ph_r <= 2'd2;
                        end
                        2'd2: if (scl_s) begin
                            ph_r <= 2'd3;
                        end
                        2'd3: begin
                            scl_oe <= 1'b1;
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_r <= bit_r + 3'd1;
                            ph_r <= 2'd0;
                            if (bit_r == TW_LAST_BIT) begin // RL10
                                state_r <= TW_FS_ACK;
                            end
                            if (is_addr_r && bit_r == TW_LAST_BIT) begin
                                role_r <= shift_r[7] ? TW_R_MRECV
                                                     : TW_R_MSEND; // RL9
                            end
                        end
                    endcase
                end
                TW_FS_ACK: if (tick) begin
                    unique case (ph_r)
                        2'd0: begin
                            sda_oe <= 1'b0;
                            ph_r <= 2'd1;
                        end
                        2'd1: begin
                            scl_oe <= 1'b0;
                            ph_r <= 2'd2;
                        end
                        2'd2: if (scl_s) begin
                            nack_r <= sda_s; // RL10
                            ph_r <= 2'd3;
                        end
                        2'd3: begin
                            scl_oe <= 1'b1; // RL11
                            if (is_addr_r) begin
                                code_r <= nack_r ? TW_C_ANACK
                                                 : TW_C_AACK; // RL17
                            end else begin
                                code_r <= nack_r ? TW_C_DNACK : TW_C_DACK;
                            end
                            is_addr_r <= 1'b0;
                            state_r <= TW_FS_HOLD;
                        end
                    endcase
                end
                TW_FS_STOP: if (tick) begin
                    unique case (ph_r)
                        2'd0: begin
                            sda_oe <= 1'b1;
                            ph_r <= 2'd1;
                        end
                        2'd1: begin
                            scl_oe <= 1'b0;
                            ph_r <= 2'd2;
                        end
                        2'd2: if (scl_s) begin
                            ph_r <= 2'd3;
                        end
                        2'd3: begin
                            // bus freed, no flag follows
                            sda_oe <= 1'b0; // RL19
                            held_r <= 1'b0;
                            state_r <= TW_FS_IDLE;
                        end
                    endcase
                end
                default: state_r <= TW_FS_IDLE;
            endcase
        end
    end
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // interrupt: complete, not-acknowledge, write collision
    logic [TW_NIRQ-1:0] ev;
    assign ev = {coll, set_flag && state_r == TW_FS_ACK && nack_r, set_flag};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= '0;
        end else if (wr && hit(paddr, TW_IRQC_OFS)) begin
            ists_r <= (ists_r & ~pwdata[TW_NIRQ-1:0]) | ev;
        end else begin
            ists_r <= ists_r | ev;
        end
    end
    assign irq = |(ists_r & iena_r);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ack_end;
        tick && state_r == TW_FS_ACK && ph_r == 2'd3;
    endsequence
    sequence s_hold_flag;
        state_r == TW_FS_HOLD && flag_r;
    endsequence
    property p_start_flag;
        tick && state_r == TW_FS_START && ph_r == 2'd3 |=> s_hold_flag;
    endproperty
    a_start_flag: assert property (p_start_flag) // RL1
        else $error("flag not set after start");
    property p_ack_flag;
        s_ack_end |=> s_hold_flag ##0 scl_oe;
    endproperty
    a_ack_flag: assert property (p_ack_flag) // RL2
        else $error("flag not set after acknowledge");
    property p_data_code;
        (s_ack_end and !is_addr_r)
            |=> code_r == ($past(nack_r) ? TW_C_DNACK : TW_C_DACK);
    endproperty
    a_data_code: assert property (p_data_code) // RL3
        else $error("data step code wrong");
    property p_mask;
        acc && !pwrite && hit(paddr, TW_STAT_OFS) && !flag_r
            |-> prdata[7:3] == TW_C_NONE;
    endproperty
    a_mask: assert property (p_mask) // RL4
        else $error("status without flag not f8");
    property p_resume;
        state_r == TW_FS_HOLD && go && !pwdata[TW_B_STA] &&
            !pwdata[TW_B_STO] && !set_flag |=> state_r == TW_FS_BIT && !flag_r;
    endproperty
    a_resume: assert property (p_resume) // RL5
        else $error("byte not started after clear");
    property p_suspend;
        s_hold_flag |-> scl_oe;
    endproperty
    a_suspend: assert property (p_suspend) // RL11
        else $error("clock released while flag set");
    property p_start_code;
        tick && state_r == TW_FS_START && ph_r == 2'd3 && !held_r
            |=> code_r == TW_C_START;
    endproperty
    a_start_code: assert property (p_start_code) // RL16
        else $error("start code wrong");
    property p_addr_code;
        (s_ack_end and is_addr_r)
            |=> code_r == TW_C_AACK || code_r == TW_C_ANACK;
    endproperty
    a_addr_code: assert property (p_addr_code) // RL17
        else $error("address code wrong");
    property p_no_op;
        flag_r && state_r == TW_FS_HOLD && !go |=> state_r == TW_FS_HOLD;
    endproperty
    a_no_op: assert property (p_no_op) // RL18
        else $error("operation started with flag set");
    property p_stop_noflag;
        stop_done |=> (!flag_r && state_r == TW_FS_IDLE) [*2];
    endproperty
    a_stop_noflag: assert property (p_stop_noflag) // RL19
        else $error("flag set after stop");
endmodule
`default_nettype wire

// ==== bench/tw_slave_model.sv ====
// behavioural two-wire slave receiver for the bench
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_data,
    input wire logic slow,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    logic act, first;
    logic [3:0] cnt;
    logic [7:0] sh;
    initial begin
        {act, first, cnt, sh, scl_oe, sda_oe, rx_byte, rx_stb} = '0;
    end
    always @(negedge sda) if (scl) begin
        act = 1;
        first = 1;
        cnt = 0;
    end
    always @(posedge sda) if (scl) act = 0;
    always @(posedge scl) if (act) begin
        if (cnt < 8) begin
            sh = {sh[6:0], sda};
            cnt = cnt + 1;
        end else begin
            cnt = 0;
            first = 0;
        end
    end
    always @(negedge scl) if (act) begin
        if (cnt == 8) begin
            // only a write to our own address is acked
            sda_oe = first ? (sh == {ADDR, 1'b0}) : !nack_data;
            rx_byte = sh;
            rx_stb = !rx_stb;
            if (slow) begin
                scl_oe = 1;
                #3000 scl_oe = 0;
            end
        end else sda_oe = 0;
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// bench for the two-wire master transmitter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end \
end
module tb_top;
    import tw_pkg::*;
    localparam logic [6:0] TADDR = 7'h2A;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, err;
    logic s_scl_oe, s_sda_oe, nack_data = 0, slow = 0, rx_stb;
    logic [7:0] rx_byte, exp_b;
    logic [7:0] exp_q[$];
    int n_errors = 0, check_count = 0;
    // open-drain wires with pull-ups
    wire scl_w = (scl_oe ? scl_o : 1'b1) & !s_scl_oe;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & !s_sda_oe;
    always #25 pclk = ~pclk;
    tw_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq(irq));
    tw_slave_model #(.ADDR(TADDR)) i_slave (.scl(scl_w), .sda(sda_w),
        .nack_data(nack_data), .slow(slow), .scl_oe(s_scl_oe),
        .sda_oe(s_sda_oe), .rx_byte(rx_byte), .rx_stb(rx_stb));
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // called just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // ends on the first edge that sees pready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // idle edge so a following call never drives psel twice in a step
        @(posedge pclk);
    endtask
    task automatic go(input logic [7:0] c, input logic [7:0] code);
        int n;
        n = 0;
        if (c != 0)
            apb(1, TW_CTRL_OFS, {24'h0, c});
        do begin
            apb(0, TW_CTRL_OFS, 0);
            n++;
        end while (rd[TW_B_FLAG] !== 1'b1 && n < 3000);
        apb(0, TW_STAT_OFS, 0);
        `CHK(rd[7:0] & TW_CODE_MASK, code)
    endtask
    task automatic send(input logic [7:0] b, input logic [7:0] code);
        apb(1, TW_DATA_OFS, {24'h0, b});
        exp_q.push_back(b);
        go(8'h84, code);
    endtask
    task automatic stop();
        int n;
        apb(1, TW_CTRL_OFS, 32'h94);
        for (n = 0; n < 400 && !(scl_w && sda_w); n++)
            @(posedge pclk);
        apb(0, TW_CTRL_OFS, 0);
        `CHK({scl_w, sda_w, rd[TW_B_FLAG]}, 3'b110)
    endtask
    initial begin
        @(posedge presetn);
        forever begin
            @(rx_stb);
            exp_b = exp_q.pop_front();
            `CHK(rx_byte, exp_b)
        end
    end
    initial begin
        #2000000;
        n_errors++;
        results();
    end
    initial begin
        logic [7:0] b;
        void'($urandom(55615));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, TW_STAT_OFS, 0);
        `CHK(rd[7:0], 8'hF8)
        apb(0, 8'hFC, 0);
        `CHK(err, 1'b1)
        apb(1, TW_STAT_OFS, 32'h3);
        apb(0, TW_STAT_OFS, 0);
        `CHK(rd[7:0], 8'hFB)
        apb(1, TW_STAT_OFS, 0);
        apb(1, TW_RATE_OFS, 1);
        apb(1, TW_IRQE_OFS, 7);
        $display("test regs done");
        go(8'hA4, 8'h08);
        `CHK(irq, 1'b1)
        send({TADDR, 1'b0}, 8'h18);
        apb(0, TW_ROLE_OFS, 0);
        `CHK(rd[1:0], TW_R_MSEND)
        `CHK(scl_w, 1'b0)
        for (int i = 0; i < 3; i++) begin
            slow <= (i == 1);
            send(8'($urandom), 8'h28);
        end
        nack_data <= 1;
        send(8'($urandom), 8'h30);
        nack_data <= 0;
        apb(1, TW_IRQC_OFS, 7);
        b = 8'($urandom);
        apb(1, TW_DATA_OFS, {24'h0, b});
        exp_q.push_back(b);
        apb(1, TW_CTRL_OFS, 32'h84);
        // second load lands while the byte is on the wire
        apb(1, TW_DATA_OFS, {24'h0, ~b});
        go(8'h00, 8'h28);
        apb(0, TW_IRQS_OFS, 0);
        `CHK(rd[2:0], 3'b101)
        stop();
        $display("test acked write done");
        apb(1, TW_IRQE_OFS, 0);
        go(8'hA4, 8'h08);
        `CHK(irq, 1'b0)
        send({~TADDR, 1'b0}, 8'h20);
        apb(1, TW_IRQE_OFS, 7);
        apb(0, TW_IRQS_OFS, 0);
        `CHK({irq, rd[1:0]}, 3'b111)
        go(8'hA4, 8'h10);
        send({TADDR, 1'b0}, 8'h18);
        stop();
        `CHK(exp_q.size(), 0)
        $display("test nack and restart done");
        results();
    end
endmodule
`default_nettype wire
